// ==== core/cidd_core.sv ====
// control-flow, inherent and indirect instruction decoder and executor
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - instructions that load the instruction pointer take two cycles, second is nop
// - indirect access with effective address msb set takes one extra cycle
// - word 000b branches relative by accumulator, two cycles, no flags
// - word 000a calls the accumulator-held target, two cycles
// - prefix 110100 returns, two cycles; loads literal into accumulator unless load data lands on that edge
// - word 0062 copies accumulator into option register, one cycle
// - word 0063 enters standby, updates expiry and sleep-entry flags
// - prefix 00_0000_0110_0 loads selected pin direction register
// - prefix 110001_0 adds signed six-bit literal to pointer n
// - indirect load via pointer n with update mode, sets zero flag
// - indexed load from pointer plus offset, pointer kept, zero flag
// - indirect store via pointer n with update mode, no flags
// - indexed store to pointer plus offset, pointer and flags kept
// - modes: 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
// - address is pointer, pointer +1, -1 or +k; pointer then +1, -1 or kept
// - alias registers redirect to memory at the effective address: pointer, pointer +1, -1 or +k
// - pointers are 16 bits and wrap at both limits
// - pointer updates never change status flags
// - soft reset resets device and clears soft reset flag
module cidd_core
    import cidd_pkg::*;
(
    input  wire logic              I_CORE_CLK,
    input  wire logic              I_RESET_N,
    input  wire logic [INSN_W-1:0] i_insn,
    input  wire logic [DATA_W-1:0] i_mem_rdata,
    input  wire logic              i_wake,
    output logic      [IP_W-1:0]   o_instr_pointer,
    output logic      [PTR_W-1:0]  o_mem_addr,
    output logic      [DATA_W-1:0] o_mem_wdata,
    output logic                   o_mem_rd,
    output logic                   o_mem_wr,
    output logic      [DATA_W-1:0] o_accumulator,
    output logic                   o_zero_flag,
    output logic                   o_expiry_flag,
    output logic                   o_sleep_entry_flag,
    output logic                   o_soft_reset_flag,
    output logic                   o_dog_clear,
    output logic                   o_device_reset,
    output logic                   o_standby,
    output logic      [DATA_W-1:0] o_option_reg,
    output logic      [DATA_W-1:0] o_pin_direction_reg_sel,
    output logic      [2:0]        o_pin_direction_idx,
    output logic      [PTR_W-1:0]  o_indirect_pointer0,
    output logic      [PTR_W-1:0]  o_indirect_pointer1
);
    logic             rst_meta;
    logic             rst_sync;
    cidd_state_t      state;
    logic [INSN_W-1:0] insn;
    logic [PTR_W-1:0] ptr [2];
    logic [IP_W-1:0]  ret_stack [STACK_DEPTH];
    logic [STACK_IDX_W-1:0] sp;
    logic [DATA_W-1:0] pin_dir [DIR_REGS];
    logic             pend_load;

    // decode of the latched word
    logic is_rel_jump, is_call, is_jump, is_ret_lit, is_ptr_add;
    logic is_idx_load, is_idx_store, is_ind_mode, is_dir_load;
    logic is_indirect, ptr_sel, changes_ip, push_ret, pop_ret;
    logic [PTR_W-1:0] eff_addr;
    logic [PTR_W-1:0] ptr_next;
    logic [PTR_W-1:0] sel_ptr;
    logic [IP_W-1:0]  next_ip;
    logic [DATA_W-1:0] acc_now;

    // reset release through two flip-flops; soft reset re-enters it
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= !o_device_reset;
            rst_sync <= rst_meta && !o_device_reset;
        end
    end

    function automatic logic [PTR_W-1:0] sext_ofs(input logic [OFS_W-1:0] k);
        sext_ofs = {{(PTR_W-OFS_W){k[OFS_W-1]}}, k};
    endfunction

    assign is_rel_jump  = insn[13:9]  == PFX_REL_JUMP;
    assign is_call      = insn[13:11] == PFX_ABS_CALL;
    assign is_jump      = insn[13:11] == PFX_ABS_JUMP;
    assign is_ret_lit   = insn[13:8]  == PFX_RET_LIT;
    assign is_ptr_add   = insn[13:7]  == PFX_PTR_ADD;
    assign is_idx_load  = insn[13:7]  == PFX_IDX_LOAD;
    assign is_idx_store = insn[13:7]  == PFX_IDX_STORE;
    assign is_ind_mode  = insn[13:4]  == PFX_IND_MODE;
    assign is_dir_load  = insn[13:3]  == PFX_DIR_LOAD
                          && insn != OP_OPTION_LOAD
                          && insn != OP_SLEEP
                          && insn != OP_DOG_CLEAR;
    assign is_indirect  = is_ind_mode || is_idx_load || is_idx_store;
    assign ptr_sel      = is_ind_mode ? insn[F_N_MODE] : insn[F_N_IDX];
    assign sel_ptr      = ptr[ptr_sel];
    assign push_ret     = is_call || insn == OP_CALL_W;
    assign pop_ret      = is_ret_lit || insn == OP_RETURN
                          || insn == OP_INT_RETURN;
    // control transfers spend a flush cycle
    assign changes_ip   = is_rel_jump || is_jump || push_ret || pop_ret
                          || insn == OP_BRANCH_W;
    // load data lands on the next EXEC edge, so forward it to that word
    assign acc_now      = pend_load ? i_mem_rdata : o_accumulator;

    cidd_addr_unit u_addr (
        .i_ptr      (sel_ptr),
        .i_mode     (insn[1:0]),
        .i_offset   (insn[OFS_W-1:0]),
        .i_indexed  (!is_ind_mode),
        .o_eff_addr (eff_addr),
        .o_ptr_next (ptr_next)
    );

    always_comb
    begin
        next_ip = o_instr_pointer + IP_ONE;
        if (is_rel_jump)
        begin
            next_ip = o_instr_pointer + IP_ONE
                      + {{(IP_W-9){insn[8]}}, insn[8:0]};
        end
        else if (insn == OP_BRANCH_W)
        begin
            next_ip = o_instr_pointer + IP_ONE
                      + {{(IP_W-DATA_W){1'b0}}, acc_now};
        end
        else if (insn == OP_CALL_W)
        begin
            next_ip = {{(IP_W-DATA_W){1'b0}}, acc_now};
        end
        else if (is_call || is_jump)
        begin
            next_ip = {4'h0, insn[10:0]};
        end
        else if (pop_ret)
        begin
            next_ip = ret_stack[sp - 4'h1];
        end
    end

    // sequencer: fetch, execute, optional extra or flush cycle
    always_ff @(posedge I_CORE_CLK or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            state <= CIDD_FETCH;
            insn  <= OP_NOP;
        end
        else
        begin
            case (state)
                CIDD_FETCH:
                begin
                    insn  <= i_insn;
                    state <= CIDD_EXEC;
                end
                CIDD_EXEC:
                begin
                    if (insn == OP_SLEEP)
                        state <= CIDD_STANDBY;
                    else if (is_indirect && eff_addr[PTR_W-1])
                        state <= CIDD_EXTRA;
                    else if (changes_ip)
                        state <= CIDD_FLUSH;
                    else
                        state <= CIDD_FETCH;
                end
                CIDD_STANDBY:
                begin
                    if (i_wake)
                        state <= CIDD_FETCH;
                end
                default:
                begin
                    state <= CIDD_FETCH;
                end
            endcase
        end
    end

    // instruction pointer and return stack
    always_ff @(posedge I_CORE_CLK or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            o_instr_pointer <= IP_RESET;
            sp              <= '0;
            for (int i = 0; i < STACK_DEPTH; i++)
                ret_stack[i] <= IP_RESET;
        end
        else if (state == CIDD_EXEC && insn != OP_SOFT_RESET)
        begin
            o_instr_pointer <= next_ip;
            if (push_ret)
            begin
                ret_stack[sp] <= o_instr_pointer + IP_ONE;
                sp            <= sp + 4'h1;
            end
            else if (pop_ret)
            begin
                sp <= sp - 4'h1;
            end
        end
    end

    // pointers; updates never touch status
    always_ff @(posedge I_CORE_CLK or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            ptr[0] <= PTR_RESET;
            ptr[1] <= PTR_RESET;
        end
        else if (state == CIDD_EXEC)
        begin
            if (is_ptr_add)
                ptr[insn[F_N_IDX]] <= ptr[insn[F_N_IDX]]
                                      + sext_ofs(insn[OFS_W-1:0]);
            else if (is_ind_mode)
                ptr[ptr_sel] <= ptr_next;
        end
    end

    // memory port: alias access goes to the effective address from the address unit
    always_ff @(posedge I_CORE_CLK or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            o_mem_addr  <= PTR_RESET;
            o_mem_wdata <= BYTE_ZERO;
            o_mem_rd    <= 1'b0;
            o_mem_wr    <= 1'b0;
            pend_load   <= 1'b0;
        end
        else
        begin
            o_mem_rd  <= 1'b0;
            o_mem_wr  <= 1'b0;
            pend_load <= o_mem_rd;
            if (state == CIDD_EXEC && is_indirect)
            begin
                o_mem_addr <= eff_addr;
                if (is_idx_store || (is_ind_mode && insn[F_STORE]))
                begin
                    o_mem_wdata <= acc_now;
                    o_mem_wr    <= 1'b1;
                end
                else
                begin
                    o_mem_rd <= 1'b1;
                end
            end
        end
    end

    // accumulator and zero flag; data returns the cycle after the read
    always_ff @(posedge I_CORE_CLK or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            o_accumulator <= BYTE_ZERO;
            o_zero_flag   <= 1'b0;
        end
        else if (pend_load)
        begin
            o_accumulator <= i_mem_rdata;
            o_zero_flag   <= i_mem_rdata == BYTE_ZERO;
        end
        else if (state == CIDD_EXEC && is_ret_lit)
        begin
            o_accumulator <= insn[DATA_W-1:0];
        end
    end

    // option and pin direction registers
    always_ff @(posedge I_CORE_CLK or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            o_option_reg <= OPTION_RESET;
            for (int i = 0; i < DIR_REGS; i++)
                pin_dir[i] <= DIR_RESET;
        end
        else if (state == CIDD_EXEC)
        begin
            if (insn == OP_OPTION_LOAD)
                o_option_reg <= acc_now;
            else if (is_dir_load)
                pin_dir[insn[2:0]] <= acc_now;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            o_pin_direction_reg_sel <= DIR_RESET;
            o_pin_direction_idx     <= 3'h0;
        end
        else if (state == CIDD_EXEC && is_dir_load)
        begin
            o_pin_direction_reg_sel <= acc_now;
            o_pin_direction_idx     <= insn[2:0];
        end
    end

    // power flags: set to 1 at power-on; sleep clears sleep-entry flag
    always_ff @(posedge I_CORE_CLK or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            o_expiry_flag      <= 1'b1;
            o_sleep_entry_flag <= 1'b1;
            o_standby          <= 1'b0;
            o_dog_clear        <= 1'b0;
        end
        else
        begin
            o_dog_clear <= state == CIDD_EXEC && insn == OP_DOG_CLEAR;
            if (state == CIDD_EXEC && insn == OP_SLEEP)
            begin
                o_expiry_flag      <= 1'b1;
                o_sleep_entry_flag <= 1'b0;
                o_standby          <= 1'b1;
            end
            else if (state == CIDD_EXEC && insn == OP_DOG_CLEAR)
            begin
                o_expiry_flag      <= 1'b1;
                o_sleep_entry_flag <= 1'b1;
            end
            if (state == CIDD_STANDBY && i_wake)
                o_standby <= 1'b0;
        end
    end

    // soft reset flag survives the reset it causes, so only I_RESET_N sets it
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            o_soft_reset_flag <= 1'b1;
            o_device_reset    <= 1'b0;
        end
        else
        begin
            o_device_reset <= state == CIDD_EXEC && insn == OP_SOFT_RESET;
            if (state == CIDD_EXEC && insn == OP_SOFT_RESET)
                o_soft_reset_flag <= 1'b0;
        end
    end

    assign o_indirect_pointer0 = ptr[0];
    assign o_indirect_pointer1 = ptr[1];
endmodule
`default_nettype wire

// ==== core/cidd_pkg.sv ====
// constants and types shared by the control and indirect instruction decoder
package cidd_pkg;
    localparam int          INSN_W          = 14;
    localparam int          DATA_W          = 8;
    localparam int          PTR_W           = 16;
    localparam int          IP_W            = 15;
    localparam int          STACK_DEPTH     = 16;
    localparam int          STACK_IDX_W     = 4;
    localparam int          DIR_REGS        = 8;
    localparam int          OFS_W           = 6;

    // exact opcodes
    localparam logic [13:0] OP_NOP          = 14'h0000;
    localparam logic [13:0] OP_SOFT_RESET   = 14'h0001;
    localparam logic [13:0] OP_RETURN       = 14'h0008;
    localparam logic [13:0] OP_INT_RETURN   = 14'h0009;
    localparam logic [13:0] OP_CALL_W       = 14'h000a;
    localparam logic [13:0] OP_BRANCH_W     = 14'h000b;
    localparam logic [13:0] OP_OPTION_LOAD  = 14'h0062;
    localparam logic [13:0] OP_SLEEP        = 14'h0063;
    localparam logic [13:0] OP_DOG_CLEAR    = 14'h0064;

    // prefixes, matched on the high bits
    localparam logic [10:0] PFX_DIR_LOAD    = 11'h00c;
    localparam logic [9:0]  PFX_IND_MODE    = 10'h001;
    localparam logic [4:0]  PFX_REL_JUMP    = 5'h19;
    localparam logic [2:0]  PFX_ABS_CALL    = 3'h4;
    localparam logic [2:0]  PFX_ABS_JUMP    = 3'h5;
    localparam logic [5:0]  PFX_RET_LIT     = 6'h34;
    localparam logic [6:0]  PFX_PTR_ADD     = 7'h62;
    localparam logic [6:0]  PFX_IDX_LOAD    = 7'h7e;
    localparam logic [6:0]  PFX_IDX_STORE   = 7'h7f;

    // field positions
    localparam int          F_N_MODE        = 2;
    localparam int          F_N_IDX         = 6;
    localparam int          F_STORE         = 3;

    localparam logic [1:0]  MODE_PRE_INC    = 2'h0;
    localparam logic [1:0]  MODE_PRE_DEC    = 2'h1;
    localparam logic [1:0]  MODE_POST_INC   = 2'h2;
    localparam logic [1:0]  MODE_POST_DEC   = 2'h3;

    localparam logic [15:0] PTR_RESET       = 16'h0000;
    localparam logic [15:0] PTR_ONE         = 16'h0001;
    localparam logic [14:0] IP_RESET        = 15'h0000;
    localparam logic [14:0] IP_ONE          = 15'h0001;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    localparam logic [7:0]  OPTION_RESET    = 8'hff;
    localparam logic [7:0]  DIR_RESET       = 8'hff;

    typedef enum logic [2:0] {
        CIDD_FETCH,
        CIDD_EXEC,
        CIDD_EXTRA,
        CIDD_FLUSH,
        CIDD_STANDBY
    } cidd_state_t;
endpackage

// ==== core/cidd_addr_unit.sv ====
// effective address and pointer write-back for indirect transfers
`timescale 1ns/1ps
`default_nettype none
module cidd_addr_unit
    import cidd_pkg::*;
(
    input  wire logic [PTR_W-1:0] i_ptr,
    input  wire logic [1:0]       i_mode,
    input  wire logic [OFS_W-1:0] i_offset,
    input  wire logic             i_indexed,
    output logic      [PTR_W-1:0] o_eff_addr,
    output logic      [PTR_W-1:0] o_ptr_next
);
    logic [PTR_W-1:0] ptr_inc;
    logic [PTR_W-1:0] ptr_dec;
    logic [PTR_W-1:0] ofs_ext;

    // 16-bit arithmetic wraps at both ends
    assign ptr_inc = i_ptr + PTR_ONE;
    assign ptr_dec = i_ptr - PTR_ONE;
    // offset is sign-extended before the add
    assign ofs_ext = {{(PTR_W-OFS_W){i_offset[OFS_W-1]}}, i_offset};

    always_comb
    begin
        o_eff_addr = i_ptr;
        o_ptr_next = i_ptr;
        if (i_indexed)
        begin
            o_eff_addr = i_ptr + ofs_ext;
        end
        else
        begin
            case (i_mode)
                MODE_PRE_INC:
                begin
                    o_eff_addr = ptr_inc;
                    o_ptr_next = ptr_inc;
                end
                MODE_PRE_DEC:
                begin
                    o_eff_addr = ptr_dec;
                    o_ptr_next = ptr_dec;
                end
                MODE_POST_INC:
                begin
                    o_ptr_next = ptr_inc;
                end
                default:
                begin
                    o_ptr_next = ptr_dec;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== tb/cidd_assertions.sv ====
// concurrent checks on the decoder's top-level ports
`timescale 1ns/1ps
`default_nettype none
module cidd_assertions
    import cidd_pkg::*;
(
    input  wire logic              I_CORE_CLK,
    input  wire logic              I_RESET_N,
    input  wire logic              i_wake,
    input  wire logic [PTR_W-1:0]  o_mem_addr,
    input  wire logic [DATA_W-1:0] o_mem_wdata,
    input  wire logic              o_mem_rd,
    input  wire logic              o_mem_wr,
    input  wire logic [DATA_W-1:0] o_accumulator,
    input  wire logic              o_zero_flag,
    input  wire logic              o_expiry_flag,
    input  wire logic              o_sleep_entry_flag,
    input  wire logic              o_soft_reset_flag,
    input  wire logic              o_dog_clear,
    input  wire logic              o_device_reset,
    input  wire logic              o_standby,
    input  wire logic [DATA_W-1:0] o_option_reg,
    input  wire logic [DATA_W-1:0] o_pin_direction_reg_sel,
    input  wire logic [PTR_W-1:0]  o_indirect_pointer0
);
    logic [PTR_W-1:0] prev_p0;
    logic [PTR_W-1:0] step0;

    // pointer value before the access edge, to see pre versus post update
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            prev_p0 <= PTR_RESET;
        else
            prev_p0 <= o_indirect_pointer0;
    end
    assign step0 = o_indirect_pointer0 - prev_p0;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESET_N);

    sequence store_s;
        (o_mem_wdata == o_accumulator) ##1 (!o_mem_wr && $stable(o_zero_flag));
    endsequence

    sequence soft_reset_s;
        ##[0:1] !o_soft_reset_flag ##1 !o_device_reset;
    endsequence

    read_pulse_a: assert property (o_mem_rd |=> !o_mem_rd)
        else $error("read strobe held past one cycle");
    store_data_a: assert property (o_mem_wr |-> store_s)
        else $error("store data or flags wrong");
    ptr_step_a: assert property ((o_mem_rd || o_mem_wr) |-> step0 inside {16'h0000, 16'h0001, 16'hffff})
        else $error("pointer moved by more than one");
    eff_addr_a: assert property ((o_mem_rd || o_mem_wr) && step0 != 16'h0000 |-> o_mem_addr == o_indirect_pointer0 || o_mem_addr == prev_p0)
        else $error("address is neither old nor new pointer");
    zero_match_a: assert property ($changed(o_zero_flag) && !$past(o_device_reset) |-> o_zero_flag == (o_accumulator == 8'h00))
        else $error("zero flag disagrees with accumulator");
    option_copy_a: assert property ($changed(o_option_reg) && !$past(o_device_reset) |-> o_option_reg == o_accumulator)
        else $error("option register not loaded from accumulator");
    dir_copy_a: assert property ($changed(o_pin_direction_reg_sel) && !$past(o_device_reset) |-> o_pin_direction_reg_sel == o_accumulator)
        else $error("direction value not from accumulator");
    sleep_flags_a: assert property ($rose(o_standby) |-> ##[0:1] (o_expiry_flag && !o_sleep_entry_flag))
        else $error("standby entry flags wrong");
    standby_hold_a: assert property (o_standby && !i_wake |=> o_standby)
        else $error("standby left without wake");
    dog_flags_a: assert property (o_dog_clear |-> ##[0:1] (o_expiry_flag && o_sleep_entry_flag))
        else $error("timer clear flags wrong");
    soft_reset_a: assert property (o_device_reset |-> soft_reset_s)
        else $error("soft reset flag or pulse wrong");
endmodule

bind cidd_core cidd_assertions cidd_assertions_inst (.*);
`default_nettype wire

// ==== tb/cidd_mem_model.sv ====
// program and data memory standing beside the decoder
`timescale 1ns/1ps
`default_nettype none
module cidd_mem_model
    import cidd_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic [IP_W-1:0]   i_ip,
    input  wire logic [PTR_W-1:0]  i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_rd,
    input  wire logic              i_wr,
    output logic      [INSN_W-1:0] o_insn,
    output logic      [DATA_W-1:0] o_rdata
);
    logic [INSN_W-1:0] prog [0:255];
    logic [DATA_W-1:0] ram [0:65535];

    initial o_rdata = 8'h5a;
    assign o_insn = prog[i_ip[7:0]];

    // read data is good for one cycle only; after that it toggles so a
    // late capture cannot pass by luck
    always @(posedge i_clk)
    begin
        if (i_wr)
            ram[i_addr] <= i_wdata;
        if (i_rd)
            o_rdata <= ram[i_addr];
        else
            o_rdata <= ~o_rdata;
    end
endmodule
`default_nettype wire

// ==== tb/control_and_indirect_insn_decode_tb.sv ====
// self-checking bench for the control and indirect instruction decoder
`timescale 1ns/1ps
`default_nettype none
module control_and_indirect_insn_decode_tb
    import cidd_pkg::*;
;
    localparam int JUMP_IP = 16;
    localparam int SLEEP_IP = 18;
    localparam logic [13:0] PROG [0:20] = '{
        14'h3105, 14'h317d, 14'h0010, 14'h001f, 14'h0012, 14'h0015,
        14'h3fbe, 14'h3f5f, 14'h0062, 14'h0065, 14'h2040, 14'h000b,
        14'h0000, 14'h0000, 14'h0013, 14'h0064, 14'h3201, 14'h0000,
        14'h0063, 14'h0001, 14'h2814};
    logic              I_CORE_CLK = 1'b0;
    logic              I_RESET_N = 1'b0;
    logic              i_wake = 1'b0;
    logic [INSN_W-1:0] insn;
    logic [DATA_W-1:0] rdata, wdata, acc, opt, dir;
    logic [IP_W-1:0]   ip;
    logic [PTR_W-1:0]  addr, p0, p1;
    logic              rd, wr, zf, exp_f, sle_f, srf, dogc, devr, stby;
    logic [2:0]        dir_idx;
    logic [13:0]       prog_img [0:255];
    logic [7:0]        ram_img [0:65535];
    logic [IP_W-1:0]   last_ip = '0;
    int                rd_q[$], wr_q[$], wd_q[$];
    int                m_acc, m_z, m_opt, m_dir, m_idx, exp_cyc;
    int                m_p[2];
    int                cyc = 0, t_first = -1, t_jump = -1;
    int                err_total = 0, total_checks = 0;

    cidd_core cidd_core_inst (
        .I_CORE_CLK(I_CORE_CLK), .I_RESET_N(I_RESET_N), .i_insn(insn),
        .i_mem_rdata(rdata), .i_wake(i_wake), .o_instr_pointer(ip),
        .o_mem_addr(addr), .o_mem_wdata(wdata), .o_mem_rd(rd),
        .o_mem_wr(wr), .o_accumulator(acc), .o_zero_flag(zf),
        .o_expiry_flag(exp_f), .o_sleep_entry_flag(sle_f),
        .o_soft_reset_flag(srf), .o_dog_clear(dogc),
        .o_device_reset(devr), .o_standby(stby), .o_option_reg(opt),
        .o_pin_direction_reg_sel(dir), .o_pin_direction_idx(dir_idx),
        .o_indirect_pointer0(p0), .o_indirect_pointer1(p1));

    cidd_mem_model cidd_mem_model_inst (
        .i_clk(I_CORE_CLK), .i_ip(ip), .i_addr(addr), .i_wdata(wdata),
        .i_rd(rd), .i_wr(wr), .o_insn(insn), .o_rdata(rdata));

    always #5 I_CORE_CLK = ~I_CORE_CLK;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wait_on(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 400)
        begin
            @(posedge I_CORE_CLK);
            #1;
            n++;
        end
        chk(16'(s), 16'(v));
    endtask

    // reference executor; costs are cycles from one fetch to the next
    task automatic run_model();
        int nip, cost, ea, step, st, sum;
        int stk[$];
        logic [13:0] w;
        nip = 0;
        sum = 0;
        while (nip != SLEEP_IP)
        begin
            if (nip == JUMP_IP)
                exp_cyc = sum;
            w = prog_img[nip];
            nip++;
            cost = 2;
            ea = -1;
            step = w[0] ? -1 : 1;
            st = (w[13:8] == 6'h3f) ? w[7] : w[3];
            if (w[13:7] == 7'h62)
                m_p[w[6]] = (m_p[w[6]] + int'($signed(w[5:0]))) & 'hffff;
            else if (w[13:4] == 10'h001)
            begin
                ea = (m_p[w[2]] + (w[1] ? 0 : step)) & 'hffff;
                m_p[w[2]] = (m_p[w[2]] + step) & 'hffff;
            end
            else if (w[13:8] == 6'h3f)
                ea = (m_p[w[6]] + int'($signed(w[5:0]))) & 'hffff;
            else if (w == 14'h0062)
                m_opt = m_acc;
            else if (w[13:3] == 11'h00c && w[2:0] > 3'h4)
            begin
                m_dir = m_acc;
                m_idx = w[2:0];
            end
            else if (w[13:11] == 3'h4)
            begin
                stk.push_back(nip);
                nip = w[10:0];
                cost = 3;
            end
            else if (w[13:8] == 6'h34)
            begin
                m_acc = w[7:0];
                nip = stk.pop_back();
                cost = 3;
            end
            else if (w == 14'h000b)
            begin
                nip = nip + m_acc;
                cost = 3;
            end
            else if (w[13:9] == 5'h19)
            begin
                nip = nip + int'($signed(w[8:0]));
                cost = 3;
            end
            if (ea >= 0)
            begin
                cost = cost + ea[15];
                if (st != 0)
                begin
                    ram_img[ea] = m_acc[7:0];
                    wr_q.push_back(ea);
                    wd_q.push_back(m_acc);
                end
                else
                begin
                    m_acc = ram_img[ea];
                    m_z = (m_acc == 0);
                    rd_q.push_back(ea);
                end
            end
            sum = sum + cost;
        end
    endtask

    always @(posedge I_CORE_CLK)
    begin
        #1;
        cyc++;
        if (ip !== last_ip && t_first < 0)
            t_first = cyc;
        if (ip === 15'(SLEEP_IP) && t_jump < 0)
            t_jump = cyc;
        last_ip = ip;
        if (rd === 1'b1 && rd_q.size() > 0)
            chk(addr, 16'(rd_q.pop_front()));
        if (wr === 1'b1 && wr_q.size() > 0)
        begin
            chk(addr, 16'(wr_q.pop_front()));
            chk(16'(wdata), 16'(wd_q.pop_front()));
        end
    end

    initial
    begin
        repeat (3000) @(posedge I_CORE_CLK);
        err_total++;
        final_report();
    end

    initial
    begin
        int seed;
        seed = $urandom(68637);
        for (int a = 0; a < 65536; a++)
        begin
            ram_img[a] = (a == 7) ? 8'h00 : 8'($urandom);
            cidd_mem_model_inst.ram[a] = ram_img[a];
        end
        for (int a = 0; a < 256; a++)
            prog_img[a] = (a <= 20) ? PROG[a] : 14'h0000;
        prog_img[8'h40] = 14'h3402;
        for (int a = 0; a < 256; a++)
            cidd_mem_model_inst.prog[a] = prog_img[a];
        m_acc = 0;
        m_z = 0;
        m_p = '{0, 0};
        run_model();
        repeat (2) @(posedge I_CORE_CLK);
        #1;
        chk(16'(opt), 16'(OPTION_RESET));
        chk(16'({exp_f, sle_f, srf}), 16'h0007);
        I_RESET_N = 1'b1;
        wait_on(stby, 1'b1);
        chk(16'({exp_f, sle_f}), 16'h0002);
        chk(16'(t_jump - t_first), 16'(exp_cyc));
        chk(16'(acc), 16'(m_acc));
        chk(16'(zf), 16'(m_z));
        chk(p0, 16'(m_p[0]));
        chk(p1, 16'(m_p[1]));
        chk(16'(opt), 16'(m_opt));
        chk(16'({dir_idx, dir}), 16'({m_idx[2:0], m_dir[7:0]}));
        chk(16'(cidd_mem_model_inst.ram[5]), 16'(ram_img[5]));
        chk(16'(cidd_mem_model_inst.ram[16'hfffd]), 16'(ram_img[16'hfffd]));
        chk(16'(rd_q.size() + wr_q.size()), 16'h0000);
        i_wake = 1'b1;
        wait_on(stby, 1'b0);
        i_wake = 1'b0;
        wait_on(devr, 1'b1);
        @(posedge I_CORE_CLK);
        #1;
        chk(16'(srf), 16'h0000);
        chk(16'(ip), 16'(IP_RESET));
        wait_on(stby, 1'b1);
        final_report();
    end
endmodule
`default_nettype wire
